/* File: rtl/hbe_host_bus.sv */
// Host bus emulation: 8-bit multiplexed MCU bus master
//
// Behaviour
// RULE_01: Chip select low once per access
// RULE_02: Address latch pulse high over low address
// RULE_03: Write data valid before and after strobe
// RULE_04: Ready low stretches the access
// RULE_05: Bus clock driven out on own pin
// RULE_06: Aux lines set, cleared, read by command
// RULE_07: Wait commands stall until irq level
// RULE_08: After wait, queued read proceeds normally
// RULE_09: Host keeps irq line an input; OP_AUX_DIR can still set AUX_OE_O[1] and drive it
// RULE_10: Upper address on eight output lines
// RULE_11: Low lines carry address then data
// RULE_12: Suspend may pull input lines low
// RULE_13: Latch pulse one clock, two if stalled
// RULE_14: Write strobe up to six clocks stalled
// RULE_15: Chip select rises half clock later
// RULE_16: Only extended ops change upper address
// RULE_17: Read releases bus, strobe under select
// RULE_18: Strobes exclusive, none during latch pulse
`timescale 1ns/1ps
`default_nettype none
`include "hbe_regs.svh"
module hbe_host_bus #(
    parameter int HALF_CYC = `HBE_BUS_HALF_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Command side
    input wire logic CMD_VALID_I,
    input wire hbe_pkg::hbe_cmd_type CMD_I,
    output logic CMD_READY_O,
    output logic RSP_VALID_O,
    output logic [7:0] RSP_DATA_O,
    // Multiplexed bus
    input wire logic [7:0] MUX_I,
    output logic [7:0] MUX_O,
    output logic MUX_OE_O,
    output logic [7:0] ADDR_HI_O,
    output logic CS_N_O,
    output logic ALE_O,
    output logic RD_N_O,
    output logic WR_N_O,
    // Ready and bus clock
    input wire logic WAIT_READY_IN_I,
    output logic BUS_CLOCK_O,
    // Auxiliary lines
    input wire logic [1:0] AUX_I,
    output logic [1:0] AUX_O,
    output logic [1:0] AUX_OE_O,
    // Suspend pull control
    input wire logic SUSPEND_POWER_FLAG_I,
    input wire logic PULL_LOW_CFG_I,
    output logic PULL_DN_O
);
    // ****************************************
    // Synchronisers and bus clock
    // ****************************************
    logic [11:0] sync_q;
    wire logic [7:0] mux_s = sync_q[7:0];
    wire logic [1:0] aux_s = sync_q[9:8];
    wire logic rdy_s = sync_q[10];
    wire logic susp_s = sync_q[11];
    logic bus_clk;
    logic rise;
    logic fall;

    hbe_sync #(.W(12), .RST_VAL(`HBE_SYNC_RST)) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i({SUSPEND_POWER_FLAG_I, WAIT_READY_IN_I, AUX_I, MUX_I}),
        .q_o(sync_q)
    );

    hbe_clkdiv #(.HALF(HALF_CYC)) u_div (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .bus_clk_o(bus_clk),
        .rise_o(rise),
        .fall_o(fall)
    );

    // ****************************************
    // Sequencer state
    // ****************************************
    hbe_pkg::hbe_state_type st_reg, st_next;
    hbe_pkg::hbe_cmd_type cmd_reg, cmd_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] mux_next, addr_hi_next, rsp_data_next;
    logic oe_next, cs_n_next, ale_next, rd_n_next, wr_n_next, rsp_valid_next;
    logic [1:0] aux_next, aux_oe_next;

    // Decoded command and status
    wire logic accept = CMD_VALID_I && CMD_READY_O;
    wire logic is_rd = (cmd_reg.op == hbe_pkg::OP_RD) || (cmd_reg.op == hbe_pkg::OP_RD_EXT);
    wire logic want_hi = (cmd_reg.op == hbe_pkg::OP_WAIT_HI);
    wire logic [2:0] stb_lim = is_rd ? 3'(`HBE_RD_MAX_CLK - 1) : 3'(`HBE_WR_MAX_CLK - 1); // RULE_14
    wire logic stretch = !rdy_s && (cnt_reg < stb_lim);
    wire logic ready_next = (st_next == hbe_pkg::S_IDLE);

    // Next-state and output decode
    always_comb
    begin
        st_next = st_reg;
        cmd_next = accept ? CMD_I : cmd_reg;
        cnt_next = cnt_reg;
        mux_next = MUX_O;
        oe_next = MUX_OE_O;
        addr_hi_next = ADDR_HI_O;
        cs_n_next = CS_N_O;
        ale_next = ALE_O;
        rd_n_next = RD_N_O;
        wr_n_next = WR_N_O;
        aux_next = AUX_O;
        aux_oe_next = AUX_OE_O;
        rsp_valid_next = 1'b0;
        rsp_data_next = RSP_DATA_O;
        unique case (st_reg)
            hbe_pkg::S_IDLE:
            begin
                if (accept)
                begin
                    unique case (CMD_I.op)
                        hbe_pkg::OP_RD, hbe_pkg::OP_WR, hbe_pkg::OP_RD_EXT, hbe_pkg::OP_WR_EXT:
                        begin
                            st_next = hbe_pkg::S_ADDR;
                            mux_next = CMD_I.addr_lo; // RULE_11
                            oe_next = 1'b1;
                            if (CMD_I.op == hbe_pkg::OP_RD_EXT || CMD_I.op == hbe_pkg::OP_WR_EXT)
                                addr_hi_next = CMD_I.addr_hi; // RULE_16
                        end
                        hbe_pkg::OP_AUX_SET: aux_next = AUX_O | CMD_I.data[1:0]; // RULE_06
                        hbe_pkg::OP_AUX_CLR: aux_next = AUX_O & ~CMD_I.data[1:0]; // RULE_06
                        hbe_pkg::OP_AUX_DIR: aux_oe_next = CMD_I.data[1:0]; // RULE_06
                        hbe_pkg::OP_AUX_RD:
                        begin
                            rsp_valid_next = 1'b1; // RULE_06
                            rsp_data_next = {6'h00, aux_s};
                        end
                        hbe_pkg::OP_WAIT_HI, hbe_pkg::OP_WAIT_LO: st_next = hbe_pkg::S_WAIT; // RULE_07
                        default: st_next = hbe_pkg::S_IDLE;
                    endcase
                end
            end
            hbe_pkg::S_ADDR:
            begin
                if (rise)
                begin
                    st_next = hbe_pkg::S_ALE;
                    ale_next = 1'b1; // RULE_02
                    cnt_next = 3'h0;
                end
            end
            hbe_pkg::S_ALE:
            begin
                if (rise && !rdy_s && cnt_reg == 3'h0)
                    cnt_next = 3'(`HBE_ALE_MAX_CLK - 1); // RULE_13
                else if (rise)
                begin
                    st_next = hbe_pkg::S_CS;
                    ale_next = 1'b0;
                    cs_n_next = 1'b0; // RULE_01
                    cnt_next = 3'h0;
                    if (is_rd)
                        oe_next = 1'b0; // RULE_17
                    else
                        mux_next = cmd_reg.data; // RULE_03
                end
            end
            hbe_pkg::S_CS:
            begin
                if (rise)
                begin
                    st_next = hbe_pkg::S_STB;
                    rd_n_next = !is_rd; // RULE_17
                    wr_n_next = is_rd; // RULE_18
                end
            end
            hbe_pkg::S_STB:
            begin
                if (rise && stretch)
                    cnt_next = cnt_reg + 3'h1; // RULE_04
                else if (rise)
                begin
                    st_next = hbe_pkg::S_REL;
                    rd_n_next = 1'b1;
                    wr_n_next = 1'b1;
                    if (is_rd)
                        rsp_data_next = mux_s; // RULE_17
                end
            end
            hbe_pkg::S_REL:
            begin
                if (fall)
                begin
                    st_next = hbe_pkg::S_IDLE;
                    cs_n_next = 1'b1; // RULE_15
                    oe_next = 1'b1;
                    rsp_valid_next = is_rd;
                end
            end
            hbe_pkg::S_WAIT:
            begin
                // Next queued command, usually a read, follows the wait
                if (aux_s[1] == want_hi)
                    st_next = hbe_pkg::S_IDLE; // RULE_08
            end
            default: st_next = hbe_pkg::S_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    // Sequencer and command hold
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_reg <= hbe_pkg::S_IDLE;
            cmd_reg <= '0;
            cnt_reg <= 3'h0;
            CMD_READY_O <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            cnt_reg <= cnt_next;
            CMD_READY_O <= ready_next;
        end
    end

    // Bus pins
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            MUX_O <= 8'h00;
            MUX_OE_O <= 1'b1;
            ADDR_HI_O <= 8'h00;
            CS_N_O <= 1'b1;
            ALE_O <= 1'b0;
            RD_N_O <= 1'b1;
            WR_N_O <= 1'b1;
        end
        else
        begin
            MUX_O <= mux_next;
            MUX_OE_O <= oe_next;
            ADDR_HI_O <= addr_hi_next; // RULE_10
            CS_N_O <= cs_n_next;
            ALE_O <= ale_next;
            RD_N_O <= rd_n_next;
            WR_N_O <= wr_n_next;
        end
    end

    // Aux lines, response, clock and pull
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            AUX_O <= 2'h0;
            AUX_OE_O <= 2'h0;
            RSP_VALID_O <= 1'b0;
            RSP_DATA_O <= 8'h00;
            BUS_CLOCK_O <= 1'b0;
            PULL_DN_O <= 1'b0;
        end
        else
        begin
            AUX_O <= aux_next;
            AUX_OE_O <= aux_oe_next;
            RSP_VALID_O <= rsp_valid_next;
            RSP_DATA_O <= rsp_data_next;
            BUS_CLOCK_O <= bus_clk; // RULE_05
            PULL_DN_O <= PULL_LOW_CFG_I && susp_s; // RULE_12
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    localparam int HALF_C = HALF_CYC;
    localparam int PER_C = 2 * HALF_CYC;
    logic [7:0] ale_len;
    logic [7:0] wr_len;

    // Pulse length counters
    always_ff @(posedge CLK_SYS_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ale_len <= 8'h00;
            wr_len <= 8'h00;
        end
        else
        begin
            ale_len <= ALE_O ? ale_len + 8'h01 : 8'h00;
            wr_len <= !WR_N_O ? wr_len + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    a_strobe_under_cs: assert property ((!RD_N_O || !WR_N_O) |-> !CS_N_O) else $error("strobe without select"); // RULE_01
    a_ale_addr_drive: assert property (ALE_O |-> MUX_OE_O && $stable(MUX_O)) else $error("address moved in latch"); // RULE_02
    // Write data stands from select low until select rises, around the strobe
    a_wr_data_hold: assert property ( // RULE_03
        (!CS_N_O && $past(!CS_N_O) && !is_rd) |-> MUX_OE_O && $stable(MUX_O))
        else $error("write data unstable");
    a_stb_stretch: assert property ((st_reg == hbe_pkg::S_STB && rise && stretch) |=> st_reg == hbe_pkg::S_STB) else $error("stall ignored"); // RULE_04
    a_clock_out: assert property (rise |=> BUS_CLOCK_O ##1 BUS_CLOCK_O) else $error("bus clock not out"); // RULE_05
    a_aux_set_bits: assert property ( // RULE_06
        (accept && CMD_I.op == hbe_pkg::OP_AUX_SET)
        |=> (AUX_O & $past(CMD_I.data[1:0])) == $past(CMD_I.data[1:0]))
        else $error("aux set lost");
    a_wait_hold: assert property ((st_reg == hbe_pkg::S_WAIT && aux_s[1] != want_hi) |=> st_reg == hbe_pkg::S_WAIT && !CMD_READY_O) else $error("wait left early"); // RULE_07
    a_ale_width: assert property (ALE_O |-> ale_len < 8'(`HBE_ALE_MAX_CLK * PER_C)) else $error("latch pulse too long"); // RULE_13
    a_wr_width: assert property (!WR_N_O |-> wr_len < 8'(`HBE_WR_MAX_CLK * PER_C)) else $error("write strobe too long"); // RULE_14
    // Select rises exactly half a bus clock after the strobe
    a_cs_release: assert property ( // RULE_15
        ($rose(WR_N_O) || $rose(RD_N_O)) |-> !CS_N_O ##[HALF_C:HALF_C] $rose(CS_N_O))
        else $error("select late");
    a_upper_plain: assert property ($changed(ADDR_HI_O) |-> $past(accept) && ($past(CMD_I.op) == hbe_pkg::OP_RD_EXT || $past(CMD_I.op) == hbe_pkg::OP_WR_EXT)) else $error("upper address moved"); // RULE_16
    a_rd_release: assert property (!RD_N_O |-> !MUX_OE_O && !CS_N_O) else $error("read with bus driven"); // RULE_17
    a_strobe_excl: assert property (!(ALE_O && !(RD_N_O && WR_N_O)) && (RD_N_O || WR_N_O)) else $error("strobes overlap"); // RULE_18

    c_write_done: cover property ($rose(WR_N_O) ##[1:HALF_C] $rose(CS_N_O));
    c_read_done: cover property (RSP_VALID_O && $past(st_reg) == hbe_pkg::S_REL);
    c_wait_then_rd: cover property (st_reg == hbe_pkg::S_WAIT ##1 st_reg == hbe_pkg::S_IDLE ##[1:8] st_reg == hbe_pkg::S_ADDR);
    c_long_write: cover property (!WR_N_O && wr_len == 8'(PER_C * 3));
endmodule
`default_nettype wire

/* File: rtl/hbe_regs.svh */
// Timing and reset constants of the host bus emulation block
`ifndef HBE_REGS_SVH
`define HBE_REGS_SVH
// System clock period, picoseconds
`define HBE_SYS_PERIOD_PS 5000
// Bus clock half period, picoseconds
`define HBE_BUS_HALF_PS 41600
// Bus clock half period in system cycles
`define HBE_BUS_HALF_CYC (`HBE_BUS_HALF_PS / `HBE_SYS_PERIOD_PS)
// Longest address latch pulse, bus clocks
`define HBE_ALE_MAX_CLK 2
// Longest write strobe, bus clocks
`define HBE_WR_MAX_CLK 6
// Longest read strobe, bus clocks
`define HBE_RD_MAX_CLK 5
// Synchroniser reset value: suspend, ready, aux, mux bus
`define HBE_SYNC_RST 12'h400
`endif

/* File: rtl/hbe_pkg.sv */
// Types shared by the host bus emulation block
package hbe_pkg;
    // Commands from the serial engine
    typedef enum logic [3:0] {
        OP_RD = 4'h0,
        OP_RD_EXT = 4'h1,
        OP_WR = 4'h2,
        OP_WR_EXT = 4'h3,
        OP_AUX_SET = 4'h4,
        OP_AUX_CLR = 4'h5,
        OP_AUX_DIR = 4'h6,
        OP_AUX_RD = 4'h7,
        OP_WAIT_HI = 4'h8,
        OP_WAIT_LO = 4'h9
    } hbe_op_type;
    // One command word
    typedef struct packed {
        hbe_op_type op;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] data;
    } hbe_cmd_type;
    // Bus sequencer states, Gray along the access path except S_REL back to S_IDLE
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_ALE = 3'h3,
        S_CS = 3'h2,
        S_STB = 3'h6,
        S_REL = 3'h7,
        S_WAIT = 3'h4
    } hbe_state_type;
endpackage

/* File: rtl/hbe_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module hbe_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins in, filtered levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;

    // Three-flop chain
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ff1_reg <= RST_VAL;
            ff2_reg <= RST_VAL;
            ff3_reg <= RST_VAL;
        end
        else
        begin
            ff1_reg <= d_i;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // A bit changes once stages two and three agree
    for (genvar b = 0; b < W; b++)
    begin : g_bit
        always_ff @(posedge clk_i or posedge rst_i)
        begin
            if (rst_i)
                q_o[b] <= RST_VAL[b];
            else if (ff2_reg[b] == ff3_reg[b])
                q_o[b] <= ff3_reg[b];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/hbe_clkdiv.sv */
// Bus clock divider with edge ticks
`timescale 1ns/1ps
`default_nettype none
module hbe_clkdiv #(
    parameter int HALF = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Divided clock and its edge ticks
    output logic bus_clk_o,
    output logic rise_o,
    output logic fall_o
);
    logic [7:0] cnt_reg;
    wire logic wrap = (cnt_reg == 8'(HALF - 1));

    // Toggle every half period
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 8'h00;
            bus_clk_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
            bus_clk_o <= wrap ? ~bus_clk_o : bus_clk_o;
            rise_o <= wrap && !bus_clk_o;
            fall_o <= wrap && bus_clk_o;
        end
    end
endmodule
`default_nettype wire

/* File: sim/hbe_periph_model.sv */
// Peripheral chip model on the multiplexed bus, with timing probes
`timescale 1ns/1ps
`default_nettype none
module hbe_periph_model (
    // Clock, reset and speed
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // Bus pins as seen on the board
    input wire logic cs_n_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic oe_i,
    input wire logic [7:0] mux_i,
    input wire logic [7:0] addr_hi_i,
    // Answer back
    output logic rdy_o,
    output logic drive_o,
    output logic [7:0] data_o,
    // Observed counts, system cycles
    output logic [15:0] cs_cnt_o,
    output logic [15:0] ale_len_o,
    output logic [15:0] stb_len_o,
    output logic [15:0] gap_len_o,
    output logic [15:0] viol_o,
    output logic [23:0] wr_word_o
);
    // ****************
    // Storage and pin decode
    // ****************
    logic [7:0] mem_reg [0:65535];
    logic [15:0] addr_reg;
    logic [7:0] mux_reg;
    logic ale_reg, stb_reg, cs_reg, done_reg, wr_reg;
    wire stb_on = !rd_n_i || !wr_n_i;
    // Overlapping strobes, strobe outside select, contention, data moving in a write
    wire bad = (!rd_n_i && !wr_n_i) || (ale_i && stb_on) || (stb_on && cs_n_i) || (drive_o && oe_i)
        || (!cs_n_i && !cs_reg && wr_reg && mux_i != mux_reg);

    // Unwritten places read back as the inverted low address
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem_reg[i] = 8'(~i);
    end

    // Ready held low for the whole access when slow
    assign rdy_o = !slow_i;
    // Read data only while selected and read strobe low
    assign drive_o = !cs_n_i && !rd_n_i;
    assign data_o = mem_reg[addr_reg];

    // Address latch, write store and timing counters
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {ale_reg, stb_reg, cs_reg, done_reg, wr_reg} <= 5'h04;
            {cs_cnt_o, ale_len_o, stb_len_o, gap_len_o, viol_o} <= '0;
            wr_word_o <= 24'h000000;
            addr_reg <= 16'h0000;
            mux_reg <= 8'h00;
        end
        else
        begin
            ale_reg <= ale_i;
            stb_reg <= stb_on;
            cs_reg <= cs_n_i;
            mux_reg <= mux_i;
            if (ale_i)
                addr_reg <= {addr_hi_i, mux_i};
            if (ale_i)
                ale_len_o <= ale_reg ? ale_len_o + 16'h1 : 16'h1;
            if (stb_on)
                stb_len_o <= stb_reg ? stb_len_o + 16'h1 : 16'h1;
            if (!wr_n_i)
                wr_reg <= 1'b1;
            else if (cs_n_i)
                wr_reg <= 1'b0;
            if (cs_reg && !cs_n_i)
                cs_cnt_o <= cs_cnt_o + 16'h1;
            if (stb_reg && !stb_on)
            begin
                done_reg <= 1'b1;
                gap_len_o <= 16'h1;
                if (wr_reg)
                begin
                    mem_reg[addr_reg] <= mux_i;
                    wr_word_o <= {addr_reg, mux_i};
                end
            end
            else if (done_reg && !cs_n_i)
                gap_len_o <= gap_len_o + 16'h1;
            else if (cs_n_i)
                done_reg <= 1'b0;
            if (bad)
                viol_o <= viol_o + 16'h1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/hbe_host_bus_tb.sv */
// Self-checking testbench of the host bus emulation block
`timescale 1ns/1ps
`default_nettype none
module hbe_host_bus_tb;
    // ****************
    // Clock, pins and partner
    // ****************
    localparam int HALF = 4;
    localparam int T = 2 * HALF;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    hbe_pkg::hbe_cmd_type cmd = '0;
    logic susp = 1'b0;
    logic pcfg = 1'b0;
    logic slow = 1'b0;
    logic irq = 1'b0;
    logic aux0 = 1'b0;
    logic [7:0] rsp;
    int fails = 0;
    int n_tests = 0;
    wire logic cmd_rdy, rsp_v, oe, cs_n, ale, rd_n, wr_n, bclk, pdn, p_rdy, p_drv;
    wire logic [7:0] rsp_d, mux_o, ahi, p_data, mux_w;
    wire logic [1:0] aux_o, aux_oe, aux_w;
    wire logic [15:0] cs_cnt, ale_len, stb_len, gap_len, viol;
    wire logic [23:0] wr_word;

    // Clock, 5 ns period
    always #2.5 clk = ~clk;
    // Board wires: a driver wins, else the pull resistor on mux, the irq and aux0 levels on aux
    assign mux_w = oe ? mux_o : p_drv ? p_data : {8{!pdn}};
    assign aux_w = {aux_oe[1] ? aux_o[1] : irq, aux_oe[0] ? aux_o[0] : aux0};

    hbe_host_bus #(.HALF_CYC(HALF)) u_hbe_host_bus (
        .CLK_SYS_I(clk), .RST_I(rst), .CMD_VALID_I(valid), .CMD_I(cmd), .CMD_READY_O(cmd_rdy),
        .RSP_VALID_O(rsp_v), .RSP_DATA_O(rsp_d), .MUX_I(mux_w), .MUX_O(mux_o), .MUX_OE_O(oe),
        .ADDR_HI_O(ahi), .CS_N_O(cs_n), .ALE_O(ale), .RD_N_O(rd_n), .WR_N_O(wr_n),
        .WAIT_READY_IN_I(p_rdy), .BUS_CLOCK_O(bclk), .AUX_I(aux_w), .AUX_O(aux_o), .AUX_OE_O(aux_oe),
        .SUSPEND_POWER_FLAG_I(susp), .PULL_LOW_CFG_I(pcfg), .PULL_DN_O(pdn));

    hbe_periph_model u_hbe_periph_model (
        .clk_i(clk), .rst_i(rst), .slow_i(slow), .cs_n_i(cs_n), .ale_i(ale), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .oe_i(oe), .mux_i(mux_w), .addr_hi_i(ahi), .rdy_o(p_rdy), .drive_o(p_drv),
        .data_o(p_data), .cs_cnt_o(cs_cnt), .ale_len_o(ale_len), .stb_len_o(stb_len),
        .gap_len_o(gap_len), .viol_o(viol), .wr_word_o(wr_word));

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        n_tests++;
        if (seen !== want)
        begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Waits for ready to return, keeping any response seen
    task automatic finish_op();
        int i;
        rsp = 8'hxx;
        for (i = 0; i < 400; i++)
        begin
            if (rsp_v === 1'b1)
                rsp = rsp_d;
            if (cmd_rdy === 1'b1 && i > 0)
                break;
            @(negedge clk);
        end
        if (i == 400)
        begin
            fails++;
            $display("command did not complete at %0t", $time);
        end
    endtask

    // Offers a command until taken, then optionally waits for its end
    task automatic run(input hbe_pkg::hbe_op_type op, input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] d, input bit fin);
        @(negedge clk);
        valid = 1'b1;
        cmd = '{op, hi, lo, d};
        for (int i = 0; i < 100 && cmd_rdy !== 1'b1; i++)
            @(negedge clk);
        // Command never taken counts as a mismatch
        if (cmd_rdy !== 1'b1)
            fails++;
        @(negedge clk);
        valid = 1'b0;
        if (fin)
            finish_op();
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        check({cs_n, ale, rd_n, wr_n, oe, cmd_rdy, bclk, ahi}, {7'h5c, 8'h00});
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(cmd_rdy, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_clock();
        realtime t0;
        @(posedge bclk);
        t0 = $realtime;
        @(negedge bclk);
        check(24'(int'(($realtime - t0) / 5.0)), 24'(HALF));
        @(posedge bclk);
        check(24'(int'(($realtime - t0) / 5.0)), 24'(T));
        $display("test clock done");
    endtask

    task automatic t_write();
        logic [15:0] c;
        c = cs_cnt;
        run(hbe_pkg::OP_WR_EXT, 8'h12, 8'h34, 8'h5a, 1'b1);
        check(wr_word, 24'h12345a);
        check(ahi, 8'h12);
        check(cs_cnt, c + 16'h1);
        check(ale_len, 24'(T));
        check(stb_len, 24'(T));
        check(gap_len, 24'(HALF));
        run(hbe_pkg::OP_WR, 8'h77, 8'h56, 8'ha5, 1'b1);
        check(wr_word, 24'h1256a5);
        check(viol, 16'h0);
        $display("test write done");
    endtask

    task automatic t_read();
        run(hbe_pkg::OP_RD, 8'h00, 8'h56, 8'h00, 1'b1);
        check(rsp, 8'ha5);
        check(ahi, 8'h12);
        run(hbe_pkg::OP_RD_EXT, 8'h9a, 8'h3c, 8'h00, 1'b1);
        check(rsp, 8'hc3);
        check(ahi, 8'h9a);
        check(stb_len, 24'(T));
        check(gap_len, 24'(HALF));
        check(viol, 16'h0);
        $display("test read done");
    endtask

    task automatic t_stall();
        slow = 1'b1;
        repeat (8) @(negedge clk);
        run(hbe_pkg::OP_WR_EXT, 8'h9a, 8'h3c, 8'h81, 1'b1);
        check(ale_len, 24'(2 * T));
        check(stb_len, 24'(6 * T));
        run(hbe_pkg::OP_RD, 8'h00, 8'h3c, 8'h00, 1'b1);
        check(rsp, 8'h81);
        check(stb_len, 24'(5 * T));
        check(viol, 16'h0);
        slow = 1'b0;
        repeat (8) @(negedge clk);
        $display("test stall done");
    endtask

    task automatic t_aux();
        run(hbe_pkg::OP_AUX_DIR, 8'h00, 8'h00, 8'h01, 1'b1);
        run(hbe_pkg::OP_AUX_SET, 8'h00, 8'h00, 8'h03, 1'b1);
        check({aux_oe, aux_o}, 4'h7);
        run(hbe_pkg::OP_AUX_CLR, 8'h00, 8'h00, 8'h01, 1'b1);
        check({aux_oe, aux_o}, 4'h6);
        run(hbe_pkg::OP_AUX_DIR, 8'h00, 8'h00, 8'h00, 1'b1);
        aux0 = 1'b1;
        irq = 1'b1;
        repeat (8) @(negedge clk);
        run(hbe_pkg::OP_AUX_RD, 8'h00, 8'h00, 8'h00, 1'b1);
        check(rsp, 8'h03);
        aux0 = 1'b0;
        irq = 1'b0;
        repeat (8) @(negedge clk);
        $display("test aux done");
    endtask

    task automatic t_wait();
        run(hbe_pkg::OP_WAIT_HI, 8'h00, 8'h00, 8'h00, 1'b0);
        repeat (30) @(negedge clk);
        check(cmd_rdy, 1'b0);
        irq = 1'b1;
        finish_op();
        check(cmd_rdy, 1'b1);
        run(hbe_pkg::OP_RD, 8'h00, 8'h34, 8'h00, 1'b1);
        check(rsp, 8'hcb);
        run(hbe_pkg::OP_WAIT_LO, 8'h00, 8'h00, 8'h00, 1'b0);
        repeat (30) @(negedge clk);
        check(cmd_rdy, 1'b0);
        irq = 1'b0;
        finish_op();
        check(cmd_rdy, 1'b1);
        $display("test wait done");
    endtask

    task automatic t_pull();
        pcfg = 1'b1;
        repeat (10) @(negedge clk);
        check(pdn, 1'b0);
        susp = 1'b1;
        repeat (10) @(negedge clk);
        check(pdn, 1'b1);
        pcfg = 1'b0;
        repeat (10) @(negedge clk);
        check(pdn, 1'b0);
        susp = 1'b0;
        $display("test pull done");
    endtask

    // Main sequence, reset held for 20 cycles
    initial
    begin
        repeat (20) @(negedge clk);
        t_reset();
        t_clock();
        t_write();
        t_read();
        t_stall();
        t_aux();
        t_wait();
        t_pull();
        close_out();
    end

    // Watchdog, over thirty times the expected run length
    initial
    begin
        #(20000 * 5);
        fails++;
        $display("watchdog expired at %0t", $time);
        close_out();
    end
endmodule
`default_nettype wire
